// ### verilog/timer_match_irq_flags.v
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`include "timer_irq_defs.vh"

// What this block does
// RULE1 - Timer two comparator A match sets bit 5 flag of its register.
// RULE2 - Timer two comparator P match sets bit 4 flag of its register.
// RULE3 - Timer two bit 1 is read/write comparator A interrupt enable.
// RULE4 - Timer two bit 0 is read/write comparator P interrupt enable.
// RULE5 - Timer zero comparator A match sets bit 5 flag of its register.
// RULE6 - Timer zero comparator P match sets bit 4 flag of its register.
// RULE7 - Software clears flags by writing zero; hardware never auto-clears.
// RULE8 - Bits 7:6 and 3:2 read zero and ignore writes.
// RULE9 - All flags and enables reset to zero, all software read/write.
// RULE10 - Timer zero bits 1:0 are enables; request needs flag and enable.

module timer_match_irq_flags
(
  input  wire                  clk,
  input  wire                  resetn,
  input  wire                  t2_cmpa_match,
  input  wire                  t2_cmpp_match,
  input  wire                  t0_cmpa_match,
  input  wire                  t0_cmpp_match,
  input  wire [`REG_ADDR_W-1:0] addr,
  input  wire [7:0]            wdata,
  input  wire                  wr,
  input  wire                  rd,
  output reg  [7:0]            rdata,
  output wire                  irq
);

  //--------------------------------------------------------------
  // Register decode
  //--------------------------------------------------------------

  wire [1:0] t2_flag;
  wire [1:0] t2_enable;
  wire [1:0] t0_flag;
  wire [1:0] t0_enable;
  wire       t2_req;
  wire       t0_req;
  wire       t2_wr;
  wire       t0_wr;
  wire [1:0] reg_wr;
  wire [3:0] all_match;
  wire [3:0] all_flag;
  wire [3:0] all_enable;
  wire [1:0] all_req;
  reg  [7:0] next_rdata;

  // Write strobes per register
  assign t2_wr = wr && (addr == `REG_T2_MATCH_IRQ);
  assign t0_wr = wr && (addr == `REG_T0_MATCH_IRQ);

  //--------------------------------------------------------------
  // Per-timer flag cells
  //--------------------------------------------------------------

  // Packed per-timer vectors, entry 0 is timer two, entry 1 timer zero
  assign reg_wr    = {t0_wr, t2_wr};
  assign all_match = {t0_cmpa_match, t0_cmpp_match,
                      t2_cmpa_match, t2_cmpp_match};

  // One flag cell per timer
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : gen_cell
      match_irq_cell u_cell
      (
        .clk    (clk),
        .resetn (resetn),
        .match  (all_match[2*g+1:2*g]),
        .wr_en  (reg_wr[g]),
        .wdata  (wdata),
        .flag   (all_flag[2*g+1:2*g]),
        .enable (all_enable[2*g+1:2*g]),
        .req    (all_req[g])
      );
    end
  endgenerate

  // Per-timer views of the cell outputs
  assign t2_flag   = all_flag[1:0];
  assign t2_enable = all_enable[1:0];
  assign t2_req    = all_req[0];
  assign t0_flag   = all_flag[3:2];
  assign t0_enable = all_enable[3:2];
  assign t0_req    = all_req[1];

  //--------------------------------------------------------------
  // Read path
  //--------------------------------------------------------------

  // Read mux, unimplemented bits and unmapped addresses give zero
  always @*
  begin
    next_rdata = `RESET_RDATA; // see RULE8
    case (addr)
      `REG_T2_MATCH_IRQ:
      begin
        next_rdata[`BIT_CMPA_FLAG]   = t2_flag[1];
        next_rdata[`BIT_CMPP_FLAG]   = t2_flag[0];
        next_rdata[`BIT_CMPA_ENABLE] = t2_enable[1];
        next_rdata[`BIT_CMPP_ENABLE] = t2_enable[0];
      end
      `REG_T0_MATCH_IRQ:
      begin
        next_rdata[`BIT_CMPA_FLAG]   = t0_flag[1];
        next_rdata[`BIT_CMPP_FLAG]   = t0_flag[0];
        next_rdata[`BIT_CMPA_ENABLE] = t0_enable[1];
        next_rdata[`BIT_CMPP_ENABLE] = t0_enable[0];
      end
      default:
        next_rdata = `RESET_RDATA;
    endcase
  end

  // Read data valid the cycle after the strobe only
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata <= `RESET_RDATA;
    else if (rd)
      rdata <= next_rdata;
    else
      rdata <= `RESET_RDATA;
  end

  //--------------------------------------------------------------
  // Interrupt output
  //--------------------------------------------------------------

  // Level request while any enabled flag is set
  assign irq = t2_req | t0_req; // see RULE10

endmodule

// ### verilog/timer_irq_defs.vh
`ifndef TIMER_IRQ_DEFS_VH
`define TIMER_IRQ_DEFS_VH

// Register indices (byte-wide registers on the plain port)
`define REG_T2_MATCH_IRQ   4'h0
`define REG_T0_MATCH_IRQ   4'h1
`define REG_ADDR_W         4

// Field positions
`define BIT_CMPA_FLAG      5
`define BIT_CMPP_FLAG      4
`define BIT_CMPA_ENABLE    1
`define BIT_CMPP_ENABLE    0

// Reset values
`define RESET_FLAGS        2'h0
`define RESET_ENABLES      2'h0
`define RESET_RDATA        8'h00

`endif

// ### verilog/match_irq_cell.v
`timescale 1ns/10ps
`include "timer_irq_defs.vh"

// One timer's pair of match flags and enables
module match_irq_cell
(
  input  wire       clk,
  input  wire       resetn,
  input  wire [1:0] match,
  input  wire       wr_en,
  input  wire [7:0] wdata,
  output reg  [1:0] flag,
  output reg  [1:0] enable,
  output wire       req
);

  wire [1:0] wr_flag;
  wire [1:0] wr_enable;

  // Written values split into fields, index 1 is comparator A
  assign wr_flag   = {wdata[`BIT_CMPA_FLAG], wdata[`BIT_CMPP_FLAG]};
  assign wr_enable = {wdata[`BIT_CMPA_ENABLE], wdata[`BIT_CMPP_ENABLE]};

  // Flags: match sets, software write stores; set wins over clear
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      flag <= `RESET_FLAGS; // see RULE9
    else if (wr_en)
      flag <= wr_flag | match; // see RULE7
    else
      flag <= flag | match; // see RULE1 see RULE2 see RULE5 see RULE6
  end

  // Enables: plain read/write
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      enable <= `RESET_ENABLES; // see RULE9
    else if (wr_en)
      enable <= wr_enable; // see RULE3 see RULE4 see RULE10
  end

  // Request only when flag and enable both set
  assign req = |(flag & enable); // see RULE10

endmodule

// ### test/match_src.sv
`timescale 1ns/10ps
module match_src
(
  input  wire       clk,
  input  wire [3:0] go,
  output reg  [3:0] match
);
  // Match pulse one clock after request
  always @(posedge clk) match <= go;
endmodule

// ### test/timer_match_irq_asserts.sv
`timescale 1ns/10ps
module match_irq_checks
(
  input wire clk,
  input wire resetn,
  input wire t2_cmpa_match,
  input wire t2_cmpp_match,
  input wire t0_cmpa_match,
  input wire t0_cmpp_match,
  input wire [3:0] addr,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire irq
);
  // Reads of each register
  wire r2 = rd && addr == 4'h0;
  wire r0 = rd && addr == 4'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  rd_idle_a: assert property (!$past(rd) |-> !rdata)
    else $error("rdata");
  pad_bits_a: assert property (!(rdata & 8'hCC))
    else $error("pad");
  t2a_flag_a: assert property (t2_cmpa_match ##1 r2 |=> rdata[5])
    else $error("t2a");
  t2p_flag_a: assert property (t2_cmpp_match ##1 r2 |=> rdata[4])
    else $error("t2p");
  t0a_flag_a: assert property (t0_cmpa_match ##1 r0 |=> rdata[5])
    else $error("t0a");
  t0p_flag_a: assert property (t0_cmpp_match ##1 r0 |=> rdata[4])
    else $error("t0p");
  reset_quiet_a: assert property ($rose(resetn) |-> !irq)
    else $error("irq");
  irq_fall_a: assert property ($fell(irq) |-> $past(wr))
    else $error("fall");
endmodule
bind timer_match_irq_flags match_irq_checks i_chk (.*);

// ### test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  reg        clk = 1'h0, resetn = 1'h0, wr = 1'h0, rd = 1'h0;
  reg  [3:0] addr = 4'h0, go = 4'h0, pv = 4'h0;
  reg  [7:0] wdata = 8'h00, mr [0:1] = '{8'h00, 8'h00};
  wire [3:0] m;
  wire [7:0] rdata;
  wire       irq;
  int        num_errors = 0, compares = 0, i, a;
  always #4 clk = ~clk;
  match_src i_src (.clk(clk), .go(go), .match(m));
  timer_match_irq_flags i_dut (.clk(clk), .resetn(resetn), .addr(addr),
    .t2_cmpa_match(m[0]), .t2_cmpp_match(m[1]), .t0_cmpa_match(m[2]),
    .t0_cmpp_match(m[3]), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .irq(irq));
  task chk(input string n, input [7:0] s, input [7:0] e);
    compares++;
    num_errors += s !== e;
    if (s !== e)
      $display("BAD %s exp %h seen %h", n, e, s);
  endtask
  // One bus cycle with matches; matches land an edge later
  task bus(input w, input [3:0] ad, input [3:0] v);
    wr <= w;
    rd <= !w;
    addr <= ad;
    wdata <= 8'($urandom);
    go <= v;
    @(posedge clk) #1 chk("rdata", rdata,
      w || ad > 1 ? 8'h00 : mr[ad]);
    if (w && ad < 2)
      mr[ad] = wdata & 8'h33;
    mr[0] |= {2'h0, pv[0], pv[1], 4'h0};
    mr[1] |= {2'h0, pv[2], pv[3], 4'h0};
    pv = v;
    chk("irq", {7'h0, irq},
      {7'h0, |((mr[0] & mr[0] >> 4 | mr[1] & mr[1] >> 4) & 8'h03)});
  endtask
  task wrap_up;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    a = $urandom(32'h1750);
    repeat (10) @(posedge clk);
    resetn <= 1'h1;
    for (i = 0; i < 3000; i++)
      bus(1'($urandom), 4'($urandom % 3), 4'($urandom));
    $display("random bus test done");
    wrap_up;
  end
endmodule
